// >>> spi_frame_pkg.sv
// Constants for the framed serial port control block
package spi_frame_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned CHAR_BITS      = 8;
  localparam int unsigned BIT_CNT_W      = 3;
  localparam int unsigned FRM_CNT_W      = 6;
  localparam int unsigned BUF_DEPTH_STD  = 1;
  localparam int unsigned BUF_DEPTH_DEEP = 4;
  localparam int unsigned BUF_IDX_W      = 2;
  localparam int unsigned BUF_CNT_W      = 3;
  localparam int unsigned DIV_W          = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
  localparam logic [ADDR_W-1:0] DATA_ADDR   = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] DIV_ADDR    = 4'hc;
  localparam int unsigned FRAMED_MODE_ENABLE_BIT  = 31;
  localparam int unsigned FSDIR_BIT  = 30;
  localparam int unsigned FSPOL_BIT  = 29;
  localparam int unsigned AUTOSS_BIT = 28;
  localparam int unsigned PW_BIT     = 27;
  localparam int unsigned CNT_HI     = 26;
  localparam int unsigned CNT_LO     = 24;
  localparam int unsigned EDGE_BIT   = 17;
  localparam int unsigned DEEP_BIT   = 16;
  localparam int unsigned ON_BIT     = 15;
  localparam int unsigned CKE_BIT    = 8;
  localparam int unsigned CTRL_BIT   = 5;
  localparam logic [DATA_W-1:0] CTRL_WMASK  = 32'hff03_8120;
  localparam logic [DATA_W-1:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [DIV_W-1:0]  DIV_RESET   = 8'h01;
  localparam logic [2:0] CNT_MAX_CODE = 3'h5;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b10
  } link_state_t;
endpackage

// >>> sync2.sv
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> spi_frame_sync_control.sv
// Framed serial port: control word, frame pulse logic and shifter
`timescale 1ns/1ps
`default_nettype none
module spi_frame_sync_control
  import spi_frame_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [spi_frame_pkg::ADDR_W-1:0] addr,
  input  wire logic [spi_frame_pkg::DATA_W-1:0] wdata,
  input  wire logic                           wr_en,
  input  wire logic                           rd_en,
  output var  logic [spi_frame_pkg::DATA_W-1:0] rdata,
  output var  logic                           sck_out,
  output var  logic                           sck_oe,
  input  wire logic                           sck_in,
  output var  logic                           sdo,
  input  wire logic                           sdi,
  output var  logic                           select_pin_out,
  output var  logic                           select_pin_oe,
  input  wire logic                           select_pin_in
);
  import spi_frame_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Control and data registers
  logic [DATA_W-1:0] ctrl_r;
  logic [DIV_W-1:0]  div_r;
  logic [CHAR_BITS-1:0] buf_r [BUF_DEPTH_DEEP];
  logic [BUF_IDX_W-1:0] wr_ptr_r;
  logic [BUF_IDX_W-1:0] rd_ptr_r;
  logic [BUF_CNT_W-1:0] buf_cnt_r;
  logic [CHAR_BITS-1:0] rx_data_r;
  logic                 rx_full_r;
  logic                 busy_r;

  wire logic on_w     = ctrl_r[ON_BIT];
  wire logic framed_w = ctrl_r[FRAMED_MODE_ENABLE_BIT];
  wire logic fs_in_w  = framed_w & ctrl_r[FSDIR_BIT];
  wire logic fs_pol_w = ctrl_r[FSPOL_BIT];
  wire logic ctrl_w   = ctrl_r[CTRL_BIT];
  wire logic slave_w  = framed_w ? fs_in_w : ~ctrl_w;
  wire logic [BUF_CNT_W-1:0] depth_w =
    ctrl_r[DEEP_BIT] ? BUF_CNT_W'(BUF_DEPTH_DEEP) : BUF_CNT_W'(BUF_DEPTH_STD);
  wire logic buf_push_w = wr_en && addr == DATA_ADDR && buf_cnt_r < depth_w;
  logic buf_pop_w;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RESET;
    else if (wr_en && addr == CTRL_ADDR)
    begin
      ctrl_r <= wdata & CTRL_WMASK;
      if (on_w)
        ctrl_r[DEEP_BIT] <= ctrl_r[DEEP_BIT];
      if (wdata[CNT_HI:CNT_LO] > CNT_MAX_CODE)
        ctrl_r[CNT_HI:CNT_LO] <= ctrl_r[CNT_HI:CNT_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= DIV_RESET;
    else if (wr_en && addr == DIV_ADDR && wdata[DIV_W-1:0] != '0)
      div_r <= wdata[DIV_W-1:0];
  end

  // Standard mode holds one character at a time; deep mode up to four
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      buf_cnt_r <= '0;
    end
    else if (!on_w)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      buf_cnt_r <= '0;
    end
    else
    begin
      if (buf_push_w)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (buf_pop_w)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      buf_cnt_r <= buf_cnt_r + BUF_CNT_W'(buf_push_w) - BUF_CNT_W'(buf_pop_w);
    end
  end

  always_ff @(posedge clk)
  begin
    if (buf_push_w)
      buf_r[wr_ptr_r] <= wdata[CHAR_BITS-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd_en)
    begin
      unique case (addr)
        CTRL_ADDR:   rdata <= ctrl_r;
        DATA_ADDR:   rdata <= {24'h00_0000, rx_data_r};
        STATUS_ADDR: rdata <= {26'h000_0000, busy_r, rx_full_r, 1'b0, buf_cnt_r};
        DIV_ADDR:    rdata <= {24'h00_0000, div_r};
        default:     rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_s;
  logic sdi_s;
  logic fs_s;
  sync2 u_sync_sck (.clk(clk), .rst_n(rst_n), .d(sck_in),        .q(sck_s));
  sync2 u_sync_sdi (.clk(clk), .rst_n(rst_n), .d(sdi),           .q(sdi_s));
  sync2 u_sync_fs  (.clk(clk), .rst_n(rst_n), .d(select_pin_in), .q(fs_s));

  logic sck_s_d_r;
  logic fs_act_d_r;
  wire logic fs_act_w = fs_s ~^ fs_pol_w;
  // Ordinary select is active low when not framed
  wire logic ss_act_w = framed_w ? fs_act_w : ~fs_s;
  wire logic fs_start_w = fs_act_w & ~fs_act_d_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_s_d_r  <= 1'b0;
      fs_act_d_r <= 1'b0;
    end
    else
    begin
      sck_s_d_r  <= sck_s;
      fs_act_d_r <= fs_act_w;
    end
  end
  wire logic ext_rise_w = sck_s & ~sck_s_d_r;
  wire logic ext_fall_w = ~sck_s & sck_s_d_r;

  //////////////////////////////////////////////////////////////////////////
  // Bit clock generator for controller mode
  logic [DIV_W-1:0] div_cnt_r;
  logic             tick_w;
  assign tick_w = div_cnt_r == '0;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_r <= '0;
    else if (tick_w)
      div_cnt_r <= div_r - 1'b1;
    else
      div_cnt_r <= div_cnt_r - 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Link state machine
  link_state_t          state_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [FRM_CNT_W-1:0] chr_cnt_r;
  logic [CHAR_BITS-1:0] tx_sh_r;
  logic [CHAR_BITS-1:0] rx_sh_r;
  logic                 sck_r;
  logic                 fs_out_r;
  logic                 ss_out_r;

  // Characters per pulse, one when not framed
  wire logic [FRM_CNT_W-1:0] chars_w = framed_w ?
    FRM_CNT_W'(1) << ctrl_r[CNT_HI:CNT_LO] : FRM_CNT_W'(1);
  wire logic last_chr_w = chr_cnt_r == chars_w - 1'b1;
  wire logic first_chr_w = chr_cnt_r == '0;
  wire logic have_tx_w = buf_cnt_r != '0;
  // Slave with framing waits for the pulse; without for select
  wire logic slave_go_w = framed_w ? fs_start_w : ss_act_w;
  wire logic sample_w = slave_w ? ext_rise_w : (tick_w & ~sck_r);
  wire logic shift_w  = slave_w ? ext_fall_w : (tick_w & sck_r);
  wire logic last_bit_w = bit_cnt_r == BIT_CNT_W'(CHAR_BITS - 1);

  assign buf_pop_w = on_w && have_tx_w &&
    ((state_r == ST_IDLE && (slave_w ? slave_go_w : (tick_w && !framed_w | ctrl_r[EDGE_BIT])))
     || (state_r == ST_SHIFT && shift_w && last_bit_w && !last_chr_w)
     || (state_r == ST_LEAD && tick_w && bit_cnt_r != '0));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= '0;
      chr_cnt_r <= '0;
      tx_sh_r   <= '0;
      rx_sh_r   <= '0;
      sck_r     <= 1'b0;
    end
    else if (!on_w)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= '0;
      chr_cnt_r <= '0;
      sck_r     <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          chr_cnt_r <= '0;
          bit_cnt_r <= '0;
          if (slave_w && slave_go_w)
          begin
            state_r <= ST_SHIFT;
            tx_sh_r <= have_tx_w ? buf_r[rd_ptr_r] : '0;
          end
          else if (!slave_w && have_tx_w && tick_w)
          begin
            // Early pulse spends one bit period ahead of the clock
            if (framed_w && !ctrl_r[EDGE_BIT])
              state_r <= ST_LEAD;
            else
            begin
              state_r <= ST_SHIFT;
              tx_sh_r <= buf_r[rd_ptr_r];
            end
          end
        end
        ST_LEAD:
        begin
          // Two ticks, so the early pulse spans a whole bit period
          if (tick_w && bit_cnt_r == '0)
            bit_cnt_r <= bit_cnt_r + 1'b1;
          else if (tick_w)
          begin
            state_r   <= ST_SHIFT;
            bit_cnt_r <= '0;
            tx_sh_r   <= buf_r[rd_ptr_r];
          end
        end
        ST_SHIFT:
        begin
          if (!slave_w && tick_w)
            sck_r <= ~sck_r;
          if (sample_w)
            rx_sh_r <= {rx_sh_r[CHAR_BITS-2:0], sdi_s};
          if (shift_w)
          begin
            tx_sh_r   <= {tx_sh_r[CHAR_BITS-2:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (last_bit_w)
            begin
              if (last_chr_w || (!slave_w && !have_tx_w) || (slave_w && !framed_w && !ss_act_w))
                state_r <= ST_IDLE;
              else
              begin
                chr_cnt_r <= chr_cnt_r + 1'b1;
                tx_sh_r   <= have_tx_w ? buf_r[rd_ptr_r] : '0;
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Received character and status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_data_r <= '0;
      rx_full_r <= 1'b0;
      busy_r    <= 1'b0;
    end
    else
    begin
      busy_r <= state_r != ST_IDLE;
      if (state_r == ST_SHIFT && shift_w && last_bit_w)
      begin
        rx_data_r <= rx_sh_r;
        rx_full_r <= 1'b1;
      end
      else if (rd_en && addr == DATA_ADDR)
        rx_full_r <= 1'b0;
    end
  end

  // Frame pulse and automatic select, registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_out_r <= 1'b0;
      ss_out_r <= 1'b0;
    end
    else
    begin
      fs_out_r <= 1'b0;
      if (state_r == ST_LEAD)
        fs_out_r <= 1'b1;
      else if (state_r == ST_SHIFT && first_chr_w)
      begin
        if (ctrl_r[PW_BIT])
          fs_out_r <= 1'b1;
        else if (ctrl_r[EDGE_BIT] && bit_cnt_r == '0)
          fs_out_r <= 1'b1;
      end
      ss_out_r <= state_r != ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_comb
  begin
    sck_out        = sck_r;
    sck_oe         = on_w & ~slave_w;
    sdo            = tx_sh_r[CHAR_BITS-1];
    select_pin_out = 1'b1;
    select_pin_oe  = 1'b0;
    if (on_w && framed_w && !fs_in_w)
    begin
      select_pin_out = fs_out_r ~^ fs_pol_w;
      select_pin_oe  = 1'b1;
    end
    else if (on_w && !framed_w && ctrl_w && ctrl_r[AUTOSS_BIT])
    begin
      select_pin_out = ss_out_r ~^ fs_pol_w;
      select_pin_oe  = 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> spi_frame_props.sv
// Assertion checker for the framed serial port control block
`timescale 1ns/1ps
`default_nettype none
module spi_frame_props
  import spi_frame_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic        sck_oe,
  input wire logic        select_pin_oe
);
  logic frm_r;
  logic dir_r;
  logic on_r;
  logic ctl_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // Shadow of the mode bits that every write takes as given
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {frm_r, dir_r, on_r, ctl_r} <= 4'h0;
    end
    else if (wr_en && addr == CTRL_ADDR)
    begin
      {frm_r, dir_r} <= {wdata[FRAMED_MODE_ENABLE_BIT], wdata[FSDIR_BIT]};
      {on_r, ctl_r} <= {wdata[ON_BIT], wdata[CTRL_BIT]};
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_ctrl_rd;
    rd_en && addr == CTRL_ADDR;
  endsequence
  // Settled modes: outputs may lag a control write by a cycle
  // Framed mode: direction bit alone decides who drives the clock
  sequence s_master;
    (on_r && (frm_r ? !dir_r : ctl_r)) [*3];
  endsequence
  sequence s_not_master;
    (!(on_r && (frm_r ? !dir_r : ctl_r))) [*3];
  endsequence
  AST_RDATA_ZERO: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data outside read slot");
  AST_RSVD_BITS: assert property (s_ctrl_rd |=> rdata[23:18] == 6'h0)
    else $error("unimplemented bits read nonzero");
  AST_CNT_CODE: assert property (s_ctrl_rd |=> rdata[26:24] <= CNT_MAX_CODE)
    else $error("reserved count code stored");
  AST_UNMAP: assert property (rd_en && addr[1:0] != 2'h0 |=> rdata == 32'h0)
    else $error("unmapped read nonzero");
  AST_FS_IN: assert property ((frm_r && dir_r) [*3] |-> !select_pin_oe)
    else $error("frame line driven while input");
  AST_SCK_ON: assert property (s_master |-> sck_oe)
    else $error("controller clock not driven");
  AST_SCK_OFF: assert property (s_not_master |-> !sck_oe)
    else $error("clock driven while not controller");
  AST_SEL_SLAVE: assert property ((!frm_r && !ctl_r) [*3] |-> !select_pin_oe)
    else $error("plain select driven as target");
endmodule
bind spi_frame_sync_control spi_frame_props chk
(
  .clk(clk),
  .rst_n(rst_n),
  .addr(addr),
  .wdata(wdata),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rdata(rdata),
  .sck_oe(sck_oe),
  .select_pin_oe(select_pin_oe)
);
`default_nettype wire

// >>> spi_frame_peer.sv
// Behavioural model of the far serial party
`timescale 1ns/1ps
`default_nettype none
module spi_frame_peer
(
  input  wire logic sck_out,
  input  wire logic sdo,
  output var  logic sck_in,
  output var  logic sdi,
  output var  logic fs
);
  logic [7:0] tx = 8'h0;
  logic [7:0] rx = 8'h0;
  initial
  begin
    sck_in = 1'b0;
    sdi = 1'b0;
    fs = 1'b0;
  end
  // Filler bits keep toggling so a stale line never looks valid
  task shift;
    tx = {tx[6:0], ~tx[0]};
    sdi = tx[7];
  endtask
  task load(input logic [7:0] b);
    tx = b;
    sdi = b[7];
  endtask
  always @(posedge sck_out) rx = {rx[6:0], sdo};
  always @(negedge sck_out) shift;
  // Acts as controller; clock stands still outside the frame
  task frame(input logic [7:0] b, input logic p);
    fs = p;
    load(b);
    repeat (8)
    begin
      #160 sck_in = 1'b1;
      #160 sck_in = 1'b0;
      fs = !p;
      shift;
    end
  endtask
endmodule
`default_nettype wire

// >>> spi_frame_sync_control_bench.sv
// Self-checking bench for the framed serial port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module spi_frame_sync_control_bench;
  import spi_frame_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic        sck_out, sck_oe, psck, sdo, sdi, sel_out, sel_oe, fs;
  logic        want = 1'b0;
  int          bad_count = 0;
  int          n_checks = 0;
  int          act = 0;
  // Half bit period in clocks; leaves room for the two-flop input delay
  localparam int BIT_DIV = 4;
  always #20 clk = ~clk;
  // Cycles with the select/frame line driven at its active level
  always @(posedge clk) if (sel_oe && sel_out === want) act++;
  spi_frame_sync_control dut
  (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .sck_in(sck_oe ? sck_out : psck),
    .sdo(sdo),
    .sdi(sdi),
    .select_pin_out(sel_out),
    .select_pin_oe(sel_oe),
    .select_pin_in(sel_oe ? sel_out : fs)
  );
  spi_frame_peer peer
  (
    .sck_out(sck_out),
    .sdo(sdo),
    .sck_in(psck),
    .sdi(sdi),
    .fs(fs)
  );
  ////////////////////////////////////////////////////////////////
  // Strobe then idle cycle, so no access follows a turn-off at once
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  task automatic wait_rx;
    d = 32'h0;
    for (int i = 0; i < 300 && d[4] !== 1'b1; i++)
      rd(STATUS_ADDR);
    `CHK(d[4], 1'b1)
    d = 32'h0;
  endtask
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rc(CTRL_ADDR, 32'h0);
    rc(DIV_ADDR, 32'h1);
    rc(4'h2, 32'h0);
    wr(CTRL_ADDR, 32'hffff_feff);
    rc(CTRL_ADDR, 32'hf803_8020);
    wr(CTRL_ADDR, 32'h0);
    rc(CTRL_ADDR, 32'h0001_0000);
    wr(CTRL_ADDR, 32'h0);
    rc(CTRL_ADDR, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(CTRL_ADDR, 32'h8000_0000 | (c << 24));
      rc(CTRL_ADDR, 32'h8000_0000 | ((c > 5 ? 5 : c) << 24));
    end
  endtask
  task automatic t_master;
    wr(CTRL_ADDR, 32'h0);
    wr(DIV_ADDR, BIT_DIV);
    peer.load(8'h5a);
    want <= 1'b0;
    wr(CTRL_ADDR, 32'h1000_8020);
    act = 0;
    wr(DATA_ADDR, 32'ha5);
    wait_rx;
    `CHK(peer.rx, 8'ha5)
    `CHK(act, 16 * BIT_DIV)
    rc(DATA_ADDR, 32'h5a);
  endtask
  // Pulse length at both widths and polarities; k 4 and 5 use the early edge
  task automatic t_frame_out;
    for (int k = 0; k < 6; k++)
    begin
      wr(CTRL_ADDR, 32'h0);
      want <= k[0];
      wr(CTRL_ADDR, 32'h8000_8020 | (k[2] ? 32'h0 : 32'h2_0000) | (k[0] << 29) | (k[1] << 27));
      act = 0;
      wr(DATA_ADDR, 32'h96);
      wait_rx;
      rd(DATA_ADDR);
      `CHK(act, k[1] ? 16 * BIT_DIV : 2 * BIT_DIV)
      `CHK(peer.rx, 8'h96)
    end
  endtask
  task automatic t_frame_in;
    wr(CTRL_ADDR, 32'h0);
    wr(CTRL_ADDR, 32'he000_8000);
    // Keep the far side's edges away from the sampling edge
    @(negedge clk);
    peer.frame(8'h3c, 1'b1);
    wait_rx;
    rc(DATA_ADDR, 32'h3c);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_master;
    t_frame_out;
    t_frame_in;
    conclude;
  end
  initial
  begin
    #2000000;
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
